// file: pkg/tsd_cfg.svh
// register indices, reset values and field widths of the trim and swap delay bank
`ifndef TSD_CFG_SVH
`define TSD_CFG_SVH
`define TSD_IDX_BG 8'h7C
`define TSD_IDX_TA 8'h7E
`define TSD_IDX_TB 8'h7F
`define TSD_IDX_TC 8'h80
`define TSD_IDX_TD 8'h81
`define TSD_IDX_DLY 8'h9A
`define TSD_IDX_W 8
`define TSD_BG_W 4
`define TSD_TERM_W 8
`define TSD_DLY_W 5
`define TSD_SPAN_W 7
`define TSD_DLY_RST 5'h08
`define TSD_OVL_BASE 7'h04
`define TSD_SPAN_ONE 7'h01
`define TSD_RESP_OK 2'h0
`define TSD_RESP_ERR 2'h2
`define TSD_NSEL 6
`define TSD_SEL_BG 0
`define TSD_SEL_TA 1
`define TSD_SEL_TB 2
`define TSD_SEL_TC 3
`define TSD_SEL_TD 4
`define TSD_SEL_DLY 5
`endif

// file: pkg/tsd_pkg.sv
// types shared by the trim and swap delay bank
package tsd_pkg;
    // all factory trims, as loaded from fuses and as driven to the analog side
    typedef struct packed {
        logic [3:0] bg;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] d;
    } tsd_trim_t;

    typedef enum logic [0:0] {
        TSD_IDLE = 1'b0,
        TSD_OVERLAP = 1'b1
    } tsd_swap_t;
endpackage

// file: logic/tsd_regs.sv
// trim and swap overlap delay register bank behind an axi4-lite slave
//
// What this block does
// R1: software writes zero into reserved upper bits of band-gap and delay registers.
// R2: band-gap trim is four bits 3:0, factory value after reset, read and writable.
// R3: four input termination trims, eight bits each, factory value, read and writable.
// R4: trims load from factory fuses at reset, not the printed zero.
// R5: during a core swap both cores sample together for 4 plus twice delay cycles.
// R6: swap overlap delay is five bits 4:0, range 0 to 31, resets to 0x08.
// R7: software changes the overlap delay only while calibration is disabled.
// R8: at reduced converter clock software may pick delay 7, risking large glitches.
`timescale 1ns/1ps
`include "tsd_cfg.svh"

module tsd_regs #(
    parameter int AW = 10
) (
    aclk,
    aresetn,
    awaddr,
    awvalid,
    awready,
    wdata,
    wstrb,
    wvalid,
    wready,
    bresp,
    bvalid,
    bready,
    araddr,
    arvalid,
    arready,
    rdata,
    rresp,
    rvalid,
    rready,
    fuse_trim,
    swap_start,
    trim_out,
    swap_delay_out,
    dual_sample
);
    import tsd_pkg::*;

    input wire logic aclk;
    input wire logic aresetn;
    input wire logic [AW-1:0] awaddr;
    input wire logic awvalid;
    output logic awready;
    input wire logic [31:0] wdata;
    input wire logic [3:0] wstrb;
    input wire logic wvalid;
    output logic wready;
    output logic [1:0] bresp;
    output logic bvalid;
    input wire logic bready;
    input wire logic [AW-1:0] araddr;
    input wire logic arvalid;
    output logic arready;
    output logic [31:0] rdata;
    output logic [1:0] rresp;
    output logic rvalid;
    input wire logic rready;
    input wire tsd_pkg::tsd_trim_t fuse_trim;
    input wire logic swap_start;
    output tsd_pkg::tsd_trim_t trim_out;
    output logic [`TSD_DLY_W-1:0] swap_delay_out;
    output logic dual_sample;

    // one-hot register select from a word index
    function automatic logic [`TSD_NSEL-1:0] reg_sel(input logic [`TSD_IDX_W-1:0] idx);
        reg_sel = {idx == `TSD_IDX_DLY, idx == `TSD_IDX_TD, idx == `TSD_IDX_TC,
                   idx == `TSD_IDX_TB, idx == `TSD_IDX_TA, idx == `TSD_IDX_BG};
    endfunction

    // overlap length in converter clock cycles
    function automatic logic [`TSD_SPAN_W-1:0] ovl_span(input logic [`TSD_DLY_W-1:0] dly);
        ovl_span = `TSD_OVL_BASE + {1'b0, dly, 1'b0}; // [R5]
    endfunction

    tsd_trim_t trim_ff, nxt_trim;
    logic [`TSD_DLY_W-1:0] dly_ff, nxt_dly;
    logic fuse_load_ff;
    logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff, wdata_ff;
    logic [3:0] wstrb_ff;
    logic [AW-1:0] awaddr_ff;
    logic aw_held_ff, w_held_ff;
    tsd_swap_t swap_ff, nxt_swap;
    logic [`TSD_SPAN_W-1:0] cnt_ff, nxt_cnt;
    logic dual_ff, nxt_dual;

    // write channel handshakes; address and data may arrive in either order
    wire aw_take = awvalid & awready_ff;
    wire w_take = wvalid & wready_ff;
    wire do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
    wire nxt_aw_held = do_write ? 1'b0 : (aw_held_ff | aw_take);
    wire nxt_w_held = do_write ? 1'b0 : (w_held_ff | w_take);
    wire nxt_bvalid = do_write | (bvalid_ff & ~bready);
    wire [`TSD_NSEL-1:0] wsel = reg_sel(awaddr_ff[AW-1:2]);
    wire wr_hit = |wsel;
    // only byte lane 0 carries data; other lanes land on reserved bits
    wire wr_en = do_write & wstrb_ff[0];

    // read channel: one read outstanding, answer one cycle after the address
    wire ar_take = arvalid & arready_ff;
    wire nxt_rvalid = ar_take | (rvalid_ff & ~rready);
    wire [`TSD_NSEL-1:0] rsel = reg_sel(araddr[AW-1:2]);
    wire rd_hit = |rsel;
    wire [31:0] rd_word = ({32{rsel[`TSD_SEL_BG]}} & 32'(trim_ff.bg))
                        | ({32{rsel[`TSD_SEL_TA]}} & 32'(trim_ff.a))
                        | ({32{rsel[`TSD_SEL_TB]}} & 32'(trim_ff.b))
                        | ({32{rsel[`TSD_SEL_TC]}} & 32'(trim_ff.c))
                        | ({32{rsel[`TSD_SEL_TD]}} & 32'(trim_ff.d))
                        | ({32{rsel[`TSD_SEL_DLY]}} & 32'(dly_ff)); // [R2] [R3] [R6]

    // fields are stored at their own width so reserved bits read zero even if written
    wire wr_bg = wr_en & wsel[`TSD_SEL_BG];
    wire wr_ta = wr_en & wsel[`TSD_SEL_TA];
    wire wr_tb = wr_en & wsel[`TSD_SEL_TB];
    wire wr_tc = wr_en & wsel[`TSD_SEL_TC];
    wire wr_td = wr_en & wsel[`TSD_SEL_TD];
    wire wr_dly = wr_en & wsel[`TSD_SEL_DLY];
    assign nxt_trim.bg = fuse_load_ff ? fuse_trim.bg :
                         (wr_bg ? wdata_ff[`TSD_BG_W-1:0] : trim_ff.bg); // [R2] [R4]
    assign nxt_trim.a = fuse_load_ff ? fuse_trim.a :
                        (wr_ta ? wdata_ff[`TSD_TERM_W-1:0] : trim_ff.a); // [R3] [R4]
    assign nxt_trim.b = fuse_load_ff ? fuse_trim.b :
                        (wr_tb ? wdata_ff[`TSD_TERM_W-1:0] : trim_ff.b); // [R3] [R4]
    assign nxt_trim.c = fuse_load_ff ? fuse_trim.c :
                        (wr_tc ? wdata_ff[`TSD_TERM_W-1:0] : trim_ff.c); // [R3] [R4]
    assign nxt_trim.d = fuse_load_ff ? fuse_trim.d :
                        (wr_td ? wdata_ff[`TSD_TERM_W-1:0] : trim_ff.d); // [R3] [R4]
    // no check of calibration state here; software keeps delay writes out of calibration
    assign nxt_dly = wr_dly ? wdata_ff[`TSD_DLY_W-1:0] : dly_ff; // [R6] [R7]

    // swap overlap window; a start during a running window is ignored
    always_comb begin
        nxt_swap = swap_ff;
        nxt_cnt = cnt_ff;
        nxt_dual = dual_ff;
        unique case (swap_ff)
            TSD_IDLE: begin
                if (swap_start) begin
                    nxt_swap = TSD_OVERLAP;
                    nxt_cnt = ovl_span(dly_ff) - `TSD_SPAN_ONE; // [R5]
                    nxt_dual = 1'b1;
                end
            end
            TSD_OVERLAP: begin
                if (cnt_ff == '0) begin
                    nxt_swap = TSD_IDLE;
                    nxt_dual = 1'b0;
                end else begin
                    nxt_cnt = cnt_ff - `TSD_SPAN_ONE;
                end
            end
        endcase
    end

    // fuse contents are taken by a clocked load after reset, never inside reset itself
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim_ff <= '0;
            dly_ff <= `TSD_DLY_RST; // [R6]
            fuse_load_ff <= 1'b1; // [R4]
        end else begin
            trim_ff <= nxt_trim;
            dly_ff <= nxt_dly;
            fuse_load_ff <= 1'b0;
        end
    end

    // write channel state; ready drops while a transfer is held or a response waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `TSD_RESP_OK;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
            wready_ff <= ~nxt_w_held & ~nxt_bvalid;
            bvalid_ff <= nxt_bvalid;
            if (do_write) begin
                bresp_ff <= wr_hit ? `TSD_RESP_OK : `TSD_RESP_ERR;
            end
        end
    end

    // captured write payload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else begin
            if (aw_take) begin
                awaddr_ff <= awaddr;
            end
            if (w_take) begin
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end
        end
    end
    // read channel; unmapped words answer slverr with zero data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= `TSD_RESP_OK;
        end else begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (ar_take) begin
                rdata_ff <= rd_word;
                rresp_ff <= rd_hit ? `TSD_RESP_OK : `TSD_RESP_ERR;
            end
        end
    end
    // swap window state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swap_ff <= TSD_IDLE;
            cnt_ff <= '0;
            dual_ff <= 1'b0;
        end else begin
            swap_ff <= nxt_swap;
            cnt_ff <= nxt_cnt;
            dual_ff <= nxt_dual;
        end
    end
    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign trim_out = trim_ff;
    assign swap_delay_out = dly_ff;
    assign dual_sample = dual_ff;
    // helper: run length of the overlap window and the span it was started with
    logic [`TSD_SPAN_W-1:0] run_ff, span_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_ff <= '0;
            span_ff <= '0;
        end else begin
            run_ff <= dual_ff ? run_ff + `TSD_SPAN_ONE : '0;
            if (swap_ff == TSD_IDLE && swap_start) begin
                span_ff <= ovl_span(dly_ff);
            end
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_fuse_load;
        fuse_load_ff |=> trim_ff == $past(fuse_trim);
    endproperty
    a_fuse_load: assert property (p_fuse_load) else $error("trims not loaded from fuses"); // [R4]
    property p_bg_write;
        wr_bg & ~fuse_load_ff |=> trim_ff.bg == $past(wdata_ff[`TSD_BG_W-1:0]);
    endproperty
    a_bg_write: assert property (p_bg_write) else $error("band-gap trim write lost"); // [R2]
    property p_bg_read;
        ar_take & rsel[`TSD_SEL_BG] |=> rdata_ff == 32'($past(trim_ff.bg)) && rvalid_ff;
    endproperty
    a_bg_read: assert property (p_bg_read) else $error("band-gap trim readback wrong"); // [R2]
    property p_ta_write;
        wr_ta & ~fuse_load_ff |=> trim_ff.a == $past(wdata_ff[`TSD_TERM_W-1:0]);
    endproperty
    a_ta_write: assert property (p_ta_write) else $error("input a trim write lost"); // [R3]
    property p_dly_reset;
        fuse_load_ff |-> dly_ff == `TSD_DLY_RST;
    endproperty
    a_dly_reset: assert property (p_dly_reset) else $error("overlap delay reset wrong"); // [R6]
    property p_ovl_start;
        swap_ff == TSD_IDLE && swap_start |=> dual_ff;
    endproperty
    a_ovl_start: assert property (p_ovl_start) else $error("overlap did not start"); // [R5]
    property p_ovl_len;
        $fell(dual_ff) |-> $past(run_ff) + `TSD_SPAN_ONE == span_ff;
    endproperty
    a_ovl_len: assert property (p_ovl_len) else $error("overlap length wrong"); // [R5]
    c_write: cover property (do_write && wr_hit);
    c_bad_read: cover property (ar_take && !rd_hit);
    c_swap: cover property ($fell(dual_ff));
endmodule

// file: sim/testbench.sv
// self-checking bench for the trim and swap overlap delay register bank
`timescale 1ns/1ps
`include "tsd_cfg.svh"

module testbench;
    import tsd_pkg::*;
    localparam logic [35:0] FUSE = {4'h5, 8'hA1, 8'hB2, 8'hC3, 8'hD4};
    logic aclk, aresetn;
    logic [9:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    tsd_trim_t fuse_trim, trim_out;
    logic swap_start, dual_sample;
    logic [`TSD_DLY_W-1:0] swap_delay_out;
    int n_errors, n_tests, cyc;
    logic [7:0] idx [5];
    logic [31:0] fv [5];
    logic [31:0] nv [5];
    int dl [3];

    tsd_regs #(.AW(10)) tsd_regs_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .fuse_trim(fuse_trim), .swap_start(swap_start), .trim_out(trim_out),
        .swap_delay_out(swap_delay_out), .dual_sample(dual_sample));

    // 250 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors = n_errors + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
        n_tests = n_tests + 1;
        if (g !== e) begin
            n_errors = n_errors + 1;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // axi4-lite write; address and data offered together, each released when taken
    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er,
                      input logic [3:0] st = 4'hF);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= st;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                chk("bresp", er, bresp);
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // axi4-lite read; rready held until the data arrives
    task automatic rd(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                chk("rdata", ed, rdata);
                chk("rresp", er, rresp);
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // set the overlap delay, start a swap, pulse start again mid-window, count overlap cycles
    task automatic swp(input int d);
        int cnt;
        logic first;
        cnt = 0;
        wr({`TSD_IDX_DLY, 2'b00}, d, `TSD_RESP_OK); // upper bits zero, no cal
        rd({`TSD_IDX_DLY, 2'b00}, d, `TSD_RESP_OK);
        chk("swap_delay_out", d, swap_delay_out);
        @(posedge aclk);
        swap_start <= 1'b1;
        @(posedge aclk);
        swap_start <= 1'b0;
        for (int i = 0; i < 80; i++) begin
            @(posedge aclk);
            if (i == 0) first = dual_sample;
            swap_start <= (i == 1);
            if (dual_sample === 1'b1) cnt++;
        end
        chk("dual_sample start", 1'b1, first);
        chk("overlap cycles", 4 + 2 * d, cnt);
    endtask

    initial begin
        aresetn = 1'b0;
        awaddr = '0;
        araddr = '0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        wdata = '0;
        wstrb = '0;
        swap_start = 1'b0;
        fuse_trim = FUSE;
        n_errors = 0;
        n_tests = 0;
        cyc = 0;
        idx = '{`TSD_IDX_BG, `TSD_IDX_TA, `TSD_IDX_TB, `TSD_IDX_TC, `TSD_IDX_TD};
        fv = '{{28'h0, FUSE[35:32]}, FUSE[31:24], FUSE[23:16], FUSE[15:8], FUSE[7:0]};
        nv = '{32'h0A, 32'h5A, 32'hA5, 32'h00, 32'hFF};
        dl = '{0, 7, 31};
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("trim_out", FUSE, trim_out);
        chk("swap_delay_out", `TSD_DLY_RST, swap_delay_out);
        rd({`TSD_IDX_DLY, 2'b00}, 32'h08, `TSD_RESP_OK);
        // fuse value first, then a software value, read back on every trim
        for (int i = 0; i < 5; i++) begin
            rd({idx[i], 2'b00}, fv[i], `TSD_RESP_OK);
            wr({idx[i], 2'b00}, nv[i], `TSD_RESP_OK);
            rd({idx[i], 2'b00}, nv[i], `TSD_RESP_OK);
        end
        chk("trim_out", {nv[0][3:0], nv[1][7:0], nv[2][7:0], nv[3][7:0], nv[4][7:0]},
            trim_out);
        // lane 0 not strobed: the write is answered but nothing is stored
        wr({idx[0], 2'b00}, 32'h03, `TSD_RESP_OK, 4'hE);
        rd({idx[0], 2'b00}, nv[0], `TSD_RESP_OK);
        // unmapped places answer with an error and store nothing
        wr(10'h3FC, 32'h11, `TSD_RESP_ERR);
        rd(10'h000, 32'h0, `TSD_RESP_ERR);
        chk("trim_out", {nv[0][3:0], nv[1][7:0], nv[2][7:0], nv[3][7:0], nv[4][7:0]},
            trim_out);
        // smallest, reduced-clock and largest overlap settings
        for (int i = 0; i < 3; i++) begin
            swp(dl[i]);
        end
        // a second reset reloads the fuses and the delay default
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("trim_out", FUSE, trim_out);
        chk("swap_delay_out", `TSD_DLY_RST, swap_delay_out);
        rd({`TSD_IDX_BG, 2'b00}, fv[0], `TSD_RESP_OK);
        give_verdict();
    end
endmodule
